// File: verilog/motion_sensor_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 motion sensor register port. Assumes a 50 MHz core clock.
*/
// Function
// - first serial clock rise samples direction bit
// - direction low reads, high writes, seven address bits
// - read data driven within 250 ns
// - power-on reset clears whole device
// - config bit 7 write performs soft reset
// - other bits of reset write are kept
// - device clears reset bit itself
// - logic ready at once, results after 3 frames
// - config bit 6 powers analog down
// - bit 0 clear sleeps after 1 s
// - status: part code, reserved zeros, awake flag
// - vertical motion accumulates, clears on read
// - horizontal motion accumulates, clears on read
// - quality reports upper eight of nine bits
// - image statistics and sample port mapped 0x05-0x08
// - write: direction 1, address, data, rising sampling
// - late transaction resets serial port
// - unmapped writes ignored, unmapped reads zero
`ifndef MOTION_SENSOR_MAP_SVH
`define MOTION_SENSOR_MAP_SVH

`define REG_CONFIG          7'h00
`define REG_STATE           7'h01
`define REG_VERTICAL        7'h02
`define REG_HORIZONTAL      7'h03
`define REG_QUALITY         7'h04
`define REG_BRIGHTEST       7'h05
`define REG_DARKEST         7'h06
`define REG_TOTAL           7'h07
`define REG_SAMPLE_PORT     7'h08
`define REG_EXPOSURE_UPPER  7'h09
`define REG_EXPOSURE_LOWER  7'h0A
`define REG_COMPLEMENT      7'h11

`define SOFT_RESET_BIT      7
`define ANALOG_SHUTDOWN_BIT 6
`define STAY_AWAKE_BIT      0

`define CONFIG_RESET        8'h00
`define MOTION_RESET        8'h00

`define HEADER_BITS         5'h08
`define FRAME_BITS          5'h10

`define CORE_CLK_HZ         50000000
`define PORT_TIMEOUT_MS     90
`define PORT_TIMEOUT_CYCLES (`PORT_TIMEOUT_MS * (`CORE_CLK_HZ / 1000))
`define FRAME_RATE_FPS      1500
`define FRAME_CYCLES        (`CORE_CLK_HZ / `FRAME_RATE_FPS)
`define SLEEP_TIME_S        1
`define SLEEP_CYCLES        (`SLEEP_TIME_S * `CORE_CLK_HZ)
`define SETTLE_FRAMES       2'h3

`endif

// File: verilog/motion_sensor_pkg.sv
/*
 Types of the motion sensor register port: the sample carrier from the
 image pipeline and the state of both clock domains.
 Assumes the pipeline runs on the core clock.
*/
package motion_sensor_pkg;

	typedef struct packed {
		logic        valid;
		logic [7:0]  dx;
		logic [7:0]  dy;
		logic [8:0]  features;
		logic [5:0]  brightest;
		logic [5:0]  darkest;
		logic [7:0]  total;
		logic [7:0]  pixel;
		logic [15:0] exposure;
	} motion_sample_t;

	typedef struct packed {
		logic [1:0]  rst_sync;
		logic [4:0]  wgray;
		logic [15:0] ring;
	} link_state_t;

	typedef struct packed {
		logic [4:0]  wgray_s1;
		logic [4:0]  wgray_s2;
		logic [4:0]  rptr;
		logic        sck_s1;
		logic        sck_s2;
		logic [4:0]  bit_cnt;
		logic        dir;
		logic [6:0]  addr;
		logic [7:0]  wdata;
		logic [7:0]  shift_out;
		logic        sdio_out;
		logic        sdio_oe;
		logic        hold_last;
		logic [22:0] port_timer;
		logic [7:0]  config_control;
		logic        awake;
		logic [25:0] sleep_timer;
		logic [15:0] frame_timer;
		logic [1:0]  settle_cnt;
		logic        settled;
		logic [7:0]  vertical_motion;
		logic [7:0]  horizontal_motion;
		logic [7:0]  feature_quality;
		logic [5:0]  brightest_sample;
		logic [5:0]  darkest_sample;
		logic [7:0]  sample_total;
		logic [7:0]  image_sample_port;
		logic [15:0] exposure;
		logic        pixel_rearm;
	} core_state_t;

endpackage

// File: verilog/motion_sensor_register_port.sv
/*
 Register bank and serial port of the motion sensor. The serial clock
 domain only syncs its reset and records data bits into a small ring with a gray write pointer;
 the core clock domain decodes transactions, times them out, drives the
 data line and keeps the registers.
 Assumes the host keeps the serial timing of the two-wire port and that
 the image pipeline delivers samples on the core clock.
*/
`timescale 1ns/1ns
`include "motion_sensor_map.svh"

module motion_sensor_register_port
	import motion_sensor_pkg::*;
#(
	parameter int unsigned PORT_TIMEOUT_CYCLES = `PORT_TIMEOUT_CYCLES,
	parameter int unsigned FRAME_CYCLES        = `FRAME_CYCLES,
	parameter int unsigned SLEEP_CYCLES        = `SLEEP_CYCLES,
	// part code value is arbitrary
	parameter logic [2:0]  PART_CODE           = 3'h5
) (
	// core clock and power-on reset
	input  wire logic           core_clk,
	input  wire logic           rst_n,
	// serial link
	input  wire logic           serial_clk,
	input  wire logic           sdio_in,
	output wire logic           sdio_out,
	output wire logic           sdio_oe,
	// image pipeline results
	input  wire motion_sample_t sample,
	// analog and mode control
	output wire logic           analog_shutdown,
	output wire logic           awake,
	output wire logic           results_valid,
	output wire logic           pixel_rearm
);

	link_state_t ls;
	link_state_t next_ls;
	core_state_t s;
	core_state_t next_s;

	logic [4:0] wbin;
	logic [4:0] link_bin;
	logic       rx_bit;
	logic       frame_tick;
	logic       take;
	logic       moved;
	logic       clear_v;
	logic       clear_h;
	logic [7:0] rdata;

	function automatic logic [4:0] gray2bin(input logic [4:0] g);
		logic [4:0] b;
		b[4] = g[4];
		for (int i = 3; i >= 0; i--) begin
			b[i] = b[i + 1] ^ g[i];
		end
		return b;
	endfunction

	function automatic logic [4:0] bin2gray(input logic [4:0] b);
		return b ^ {1'b0, b[4:1]};
	endfunction

	// saturating signed add keeps a fast swipe from wrapping direction
	function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] sum;
		sum = {a[7], a} + {b[7], b};
		if (sum[8] != sum[7]) begin
			return sum[8] ? 8'h80 : 8'h7F;
		end
		return sum[7:0];
	endfunction

	function automatic logic [7:0] read_reg(input core_state_t st, input logic [6:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == `REG_CONFIG) begin
			d = st.config_control;
		end else if (a == `REG_STATE) begin
			d = {PART_CODE, 4'h0, st.awake};
		end else if (a == `REG_VERTICAL) begin
			d = st.vertical_motion;
		end else if (a == `REG_HORIZONTAL) begin
			d = st.horizontal_motion;
		end else if (a == `REG_QUALITY) begin
			d = st.feature_quality;
		end else if (a == `REG_BRIGHTEST) begin
			d = {2'h0, st.brightest_sample};
		end else if (a == `REG_DARKEST) begin
			d = {2'h0, st.darkest_sample};
		end else if (a == `REG_TOTAL) begin
			d = st.sample_total;
		end else if (a == `REG_SAMPLE_PORT) begin
			d = st.image_sample_port;
		end else if (a == `REG_EXPOSURE_UPPER) begin
			d = st.exposure[15:8];
		end else if (a == `REG_EXPOSURE_LOWER) begin
			d = st.exposure[7:0];
		end else if (a == `REG_COMPLEMENT) begin
			d = ~{PART_CODE, 5'h00};
		end else begin
			d = 8'h00;
		end
		return d;
	endfunction

	function automatic core_state_t reset_state();
		core_state_t r;
		r = '0;
		r.config_control = `CONFIG_RESET;
		r.awake = 1'b1;
		r.vertical_motion = `MOTION_RESET;
		r.horizontal_motion = `MOTION_RESET;
		return r;
	endfunction

	// serial clock domain: every rising edge after the two reset sync edges is a bit, even a stray one
	assign link_bin = gray2bin(ls.wgray);

	always_comb begin
		next_ls = ls;
		next_ls.rst_sync = {ls.rst_sync[0], rst_n};
		if (!ls.rst_sync[1]) begin
			next_ls.wgray = 5'h00;
			next_ls.ring = 16'h0000;
		end else begin
			next_ls.ring[link_bin[3:0]] = sdio_in;
			next_ls.wgray = bin2gray(link_bin + 5'h01);
		end
	end

	always_ff @(posedge serial_clk) begin
		ls <= next_ls;
	end

	// core clock domain
	always_comb begin
		next_s = s;
		next_s.wgray_s1 = ls.wgray;
		next_s.wgray_s2 = s.wgray_s1;
		next_s.sck_s1 = serial_clk;
		next_s.sck_s2 = s.sck_s1;
		next_s.pixel_rearm = 1'b0;
		wbin = gray2bin(s.wgray_s2);
		rx_bit = 1'b0;
		clear_v = 1'b0;
		clear_h = 1'b0;
		rdata = 8'h00;

		// frame pacing and analog settling
		frame_tick = (s.frame_timer == 16'(FRAME_CYCLES - 1));
		next_s.frame_timer = frame_tick ? 16'h0000 : s.frame_timer + 16'h0001;
		if (s.config_control[`ANALOG_SHUTDOWN_BIT]) begin
			next_s.settled = 1'b0;
			next_s.settle_cnt = 2'h0;
		end else if (!s.settled && frame_tick) begin
			if (s.settle_cnt == `SETTLE_FRAMES - 2'h1) begin
				next_s.settled = 1'b1;
			end else begin
				next_s.settle_cnt = s.settle_cnt + 2'h1;
			end
		end
		// results before settling are not trusted, so they are dropped
		take = sample.valid && s.settled && !s.config_control[`ANALOG_SHUTDOWN_BIT];
		moved = take && (sample.dx != 8'h00 || sample.dy != 8'h00);

		// read data held until the serial clock falls after the last bit
		if (s.hold_last && !s.sck_s2) begin
			next_s.sdio_oe = 1'b0;
			next_s.hold_last = 1'b0;
		end

		next_s.port_timer = (s.bit_cnt != 5'h00) ? s.port_timer + 23'h000001 : 23'h000000;

		if (s.rptr != wbin) begin
			rx_bit = ls.ring[s.rptr[3:0]];
			next_s.rptr = s.rptr + 5'h01;
			next_s.bit_cnt = s.bit_cnt + 5'h01;
			if (s.bit_cnt == 5'h00) begin
				next_s.dir = rx_bit;
				next_s.port_timer = 23'h000000;
				next_s.sdio_oe = 1'b0;
				next_s.hold_last = 1'b0;
			end else if (s.bit_cnt < `HEADER_BITS) begin
				next_s.addr = {s.addr[5:0], rx_bit};
				if (s.bit_cnt == `HEADER_BITS - 5'h01 && !s.dir) begin
					rdata = read_reg(s, {s.addr[5:0], rx_bit});
					next_s.shift_out = rdata;
					next_s.sdio_out = rdata[7];
					next_s.sdio_oe = 1'b1;
					if ({s.addr[5:0], rx_bit} == `REG_VERTICAL) begin
						clear_v = 1'b1;
					end else if ({s.addr[5:0], rx_bit} == `REG_HORIZONTAL) begin
						clear_h = 1'b1;
					end else if ({s.addr[5:0], rx_bit} == `REG_SAMPLE_PORT) begin
						next_s.pixel_rearm = 1'b1;
					end
				end
			end else begin
				next_s.wdata = {s.wdata[6:0], rx_bit};
				if (!s.dir && s.bit_cnt != `FRAME_BITS - 5'h01) begin
					next_s.shift_out = {s.shift_out[6:0], 1'b0};
					next_s.sdio_out = s.shift_out[6];
				end
				if (s.bit_cnt == `FRAME_BITS - 5'h01) begin
					next_s.bit_cnt = 5'h00;
					if (!s.dir) begin
						next_s.hold_last = 1'b1;
					end else if (s.addr == `REG_CONFIG) begin
						next_s.config_control = {s.wdata[6:0], rx_bit};
					end else if (s.addr == `REG_SAMPLE_PORT) begin
						next_s.pixel_rearm = 1'b1;
					end
				end
			end
		end else if (s.bit_cnt != 5'h00 &&
			s.port_timer == 23'(PORT_TIMEOUT_CYCLES - 1)) begin
			// a transaction that outlives the timer is dropped; a write never lands, but a read has already done its clear or rearm
			next_s.bit_cnt = 5'h00;
			next_s.sdio_oe = 1'b0;
			next_s.hold_last = 1'b0;
		end

		// motion accumulators: a new count wins over a read clear
		next_s.vertical_motion = clear_v ? `MOTION_RESET : s.vertical_motion;
		next_s.horizontal_motion = clear_h ? `MOTION_RESET : s.horizontal_motion;
		if (take) begin
			next_s.vertical_motion = sat_add(next_s.vertical_motion, sample.dy);
			next_s.horizontal_motion = sat_add(next_s.horizontal_motion, sample.dx);
			next_s.feature_quality = sample.features[8:1];
			next_s.brightest_sample = sample.brightest;
			next_s.darkest_sample = sample.darkest;
			next_s.sample_total = sample.total;
			next_s.image_sample_port = sample.pixel;
			next_s.exposure = sample.exposure;
		end

		// sleep after a quiet second unless forced awake
		if (s.config_control[`STAY_AWAKE_BIT]) begin
			next_s.awake = 1'b1;
			next_s.sleep_timer = 26'h0000000;
		end else if (moved) begin
			next_s.awake = 1'b1;
			next_s.sleep_timer = 26'h0000000;
		end else if (s.awake) begin
			if (s.sleep_timer == 26'(SLEEP_CYCLES - 1)) begin
				next_s.awake = 1'b0;
				next_s.sleep_timer = 26'h0000000;
			end else begin
				next_s.sleep_timer = s.sleep_timer + 26'h0000001;
			end
		end

		// soft reset one cycle after the write; written bits survive
		if (s.config_control[`SOFT_RESET_BIT]) begin
			next_s = reset_state();
			next_s.config_control = {1'b0, s.config_control[6:0]};
			next_s.wgray_s1 = ls.wgray;
			next_s.wgray_s2 = s.wgray_s1;
			next_s.sck_s1 = serial_clk;
			next_s.sck_s2 = s.sck_s1;
			next_s.rptr = wbin;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s <= reset_state();
		end else begin
			s <= next_s;
		end
	end

	assign sdio_out = s.sdio_out;
	assign sdio_oe = s.sdio_oe;
	assign analog_shutdown = s.config_control[`ANALOG_SHUTDOWN_BIT];
	assign awake = s.awake;
	assign results_valid = s.settled;
	assign pixel_rearm = s.pixel_rearm;

endmodule

// File: testbench/motion_sensor_register_port_sva.sv
/*
 Port checker of the register port.
 Assumes the link clock rests low between transactions.
*/
`timescale 1ns/1ns
module motion_sensor_register_port_sva
	import motion_sensor_pkg::*;
#(
	parameter int unsigned FRAME_CYCLES = 20,
	parameter int unsigned SLEEP_CYCLES = 500
) (
	// clocks and reset
	input wire logic           core_clk,
	input wire logic           rst_n,
	input wire logic           serial_clk,
	// link and pipeline
	input wire logic           sdio_in,
	input wire logic           sdio_out,
	input wire logic           sdio_oe,
	input wire motion_sample_t sample,
	// status
	input wire logic           analog_shutdown,
	input wire logic           awake,
	input wire logic           results_valid,
	input wire logic           pixel_rearm
);
	logic        tgl;
	logic        tgl_s;
	logic [31:0] since_edge;
	logic [31:0] run_cnt;
	logic [31:0] idle_cnt;
	// link pulses are shorter than a core cycle, so edges are caught as a toggle
	always_ff @(posedge serial_clk) tgl <= rst_n ? !tgl : 1'b0;
	always_ff @(posedge core_clk) begin
		tgl_s <= tgl;
		since_edge <= (tgl_s != tgl) ? 32'h0 : since_edge + 32'h1;
		run_cnt <= (!rst_n || analog_shutdown) ? 32'h0 : run_cnt + 32'h1;
		idle_cnt <= (!rst_n || sample.valid) ? 32'h0 : idle_cnt + 32'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_reset_out;
		$rose(rst_n) |-> !sdio_oe && !analog_shutdown && awake
			&& !results_valid && !pixel_rearm;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
	property p_rearm_pulse;
		pixel_rearm |=> !pixel_rearm;
	endproperty
	a_rearm_pulse: assert property (p_rearm_pulse) else $error("rearm too long");
	property p_settle;
		$rose(results_valid) |-> run_cnt >= 2 * FRAME_CYCLES;
	endproperty
	a_settle: assert property (p_settle) else $error("results valid too early");
	property p_down_invalid;
		analog_shutdown [*2] |-> !results_valid;
	endproperty
	a_down_invalid: assert property (p_down_invalid) else $error("valid while down");
	property p_sleep;
		$fell(awake) |-> idle_cnt >= SLEEP_CYCLES - 4;
	endproperty
	a_sleep: assert property (p_sleep) else $error("asleep too early");
	property p_answer;
		$rose(sdio_oe) |-> since_edge <= 12;
	endproperty
	a_answer: assert property (p_answer) else $error("read answer late");
	property p_bit_move;
		sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> since_edge <= 12;
	endproperty
	a_bit_move: assert property (p_bit_move) else $error("data bit moved late");
	property p_down_write;
		$changed(analog_shutdown) |-> !sdio_oe;
	endproperty
	a_down_write: assert property (p_down_write) else $error("power change in read");
endmodule
bind motion_sensor_register_port motion_sensor_register_port_sva #(
	.FRAME_CYCLES(FRAME_CYCLES),
	.SLEEP_CYCLES(SLEEP_CYCLES)
) u_sva (
	.core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk), .sdio_in(sdio_in),
	.sdio_out(sdio_out), .sdio_oe(sdio_oe), .sample(sample), .awake(awake),
	.analog_shutdown(analog_shutdown), .results_valid(results_valid),
	.pixel_rearm(pixel_rearm)
);

// File: testbench/motion_host.sv
/*
 Host model: makes the link clock and drives or releases the data line.
 Assumes the device answers within the data-phase wait.
*/
`timescale 1ns/1ns
module motion_host (
	// toward the device
	output logic      serial_clk,
	output logic      sdio_in,
	// from the device
	input  wire logic sdio_out,
	input  wire logic sdio_oe
);
	logic drive = 1'b1;
	logic hbit  = 1'b1;
	logic held  = 1'b1;
	// a floating line shows the inverse of its last level, never a kind default
	assign sdio_in = sdio_oe ? sdio_out : (drive ? hbit : !held);
	always @(sdio_in) if (drive || sdio_oe) held = sdio_in;
	initial serial_clk = 1'b1;
	task automatic pulse(input int n);
		repeat (n) begin
			serial_clk = 1'b0;
			#6;
			serial_clk = 1'b1;
			#6;
		end
	endtask
	task automatic xfer(input logic [15:0] f, input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		serial_clk = 1'b0;
		#6;
		for (int i = 15; i > 15 - nbits; i--) begin
			drive = f[15] || i > 7;
			hbit = f[i];
			#((i > 7) ? 6 : 300);
			if (i < 8) rd[i] = sdio_in;
			serial_clk = 1'b1;
			#6;
			serial_clk = 1'b0;
			#6;
		end
		drive = 1'b1;
		#2000;
	endtask
endmodule

// File: testbench/motion_sensor_register_port_tb.sv
/*
 Bench of the register port: a register model checked against link reads.
 Assumes the host model and the bound checker.
*/
`timescale 1ns/1ns
`include "motion_sensor_map.svh"
module motion_sensor_register_port_tb
	import motion_sensor_pkg::*;
;
	localparam int TMO = 200;
	localparam int FRM = 20;
	localparam int SLP = 2000;
	// part code value is arbitrary
	localparam logic [2:0] PART = 3'h6;
	logic           core_clk = 1'b0;
	logic           rst_n, serial_clk, sdio_in, sdio_out, sdio_oe;
	logic           analog_shutdown, awake, results_valid, pixel_rearm;
	motion_sample_t sample, last;
	logic [31:0]    seed;
	int             n_fail = 0, tests_run = 0, cyc = 0, n_rearm = 0, vx = 0, vy = 0;
	motion_sensor_register_port #(
		.PORT_TIMEOUT_CYCLES(TMO), .FRAME_CYCLES(FRM), .SLEEP_CYCLES(SLP), .PART_CODE(PART)
	) uut (
		.core_clk(core_clk), .rst_n(rst_n), .serial_clk(serial_clk), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .sample(sample), .awake(awake),
		.analog_shutdown(analog_shutdown), .results_valid(results_valid),
		.pixel_rearm(pixel_rearm)
	);
	motion_host host (
		.serial_clk(serial_clk), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe)
	);
	always #10 core_clk = ~core_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int sat(input int v);
		return (v > 127) ? 127 : ((v < -128) ? -128 : v);
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] g;
		host.xfer({1'b0, a, 8'h00}, 16, g);
		chk(e, g);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] g;
		host.xfer({1'b1, a, d}, 16, g);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic send(input logic [7:0] dx, input logic [7:0] dy);
		logic [63:0] r;
		r = {rnd(), rnd()};
		@(negedge core_clk);
		sample = r[58:0];
		sample.valid = 1'b1;
		sample.dx = dx;
		sample.dy = dy;
		last = sample;
		vx = sat(vx + int'($signed(dx)));
		vy = sat(vy + int'($signed(dy)));
		@(negedge core_clk);
		sample.valid = 1'b0;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (pixel_rearm === 1'b1) n_rearm++;
		if (cyc == 30000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		logic [7:0] c;
		int         n0;
		rst_n = 1'b0;
		sample = '0;
		seed = 32'h55BF1E45;
		fork
			host.pulse(4);
			idle(5);
		join
		rst_n = 1'b1;
		host.xfer(16'h0000, 3, c);
		// a stray start is only cleared by the port timer
		idle(TMO + 20);
		rchk(`REG_STATE, {PART, 4'h0, 1'b1});
		$display("test startup done");
		c = 8'(rnd());
		c[7:6] = 2'h1;
		c[0] = 1'b1;
		wr(`REG_CONFIG, c);
		chk(8'h01, {7'h00, analog_shutdown});
		rchk(`REG_CONFIG, c);
		c[6] = 1'b0;
		wr(`REG_CONFIG, c);
		chk(8'h00, {7'h00, analog_shutdown});
		wr(7'h77, 8'(rnd()));
		wr(`REG_STATE, 8'hFE);
		rchk(7'h77, 8'h00);
		rchk(`REG_STATE, {PART, 4'h0, 1'b1});
		$display("test config done");
		for (int i = 0; i < 200 && results_valid !== 1'b1; i++) idle(1);
		chk(8'h01, {7'h00, results_valid});
		repeat (6) send(8'(rnd()), 8'(rnd()));
		rchk(`REG_VERTICAL, 8'(vy));
		vy = 0;
		rchk(`REG_HORIZONTAL, 8'(vx));
		vx = 0;
		rchk(`REG_VERTICAL, 8'(vy));
		rchk(`REG_QUALITY, last.features[8:1]);
		rchk(`REG_BRIGHTEST, {2'h0, last.brightest});
		n0 = n_rearm;
		rchk(`REG_SAMPLE_PORT, last.pixel);
		chk(8'h01, 8'(n_rearm - n0));
		$display("test motion done");
		send(8'h7F, 8'h80);
		wr(`REG_CONFIG, 8'hA1);
		idle(TMO + 20);
		rchk(`REG_CONFIG, 8'h21);
		rchk(`REG_HORIZONTAL, 8'h00);
		$display("test soft reset done");
		host.xfer({1'b1, `REG_CONFIG, 8'h40}, 12, c);
		idle(TMO + 20);
		rchk(`REG_CONFIG, 8'h21);
		$display("test timeout done");
		wr(`REG_CONFIG, 8'h00);
		idle(SLP + 50);
		chk(8'h00, {7'h00, awake});
		rchk(`REG_STATE, {PART, 4'h0, 1'b0});
		$display("test sleep done");
		finish_test();
	end
endmodule
